/* File: src/rfd_params.svh */
/*
 * Offsets, field positions, reset values and timing counts for the
 * resolver fault-detect configuration block. Assumes a 20 MHz pclk.
 */
// Summary of operation
// - Short deglitch select: 35-140 us, resets 111
// - Exciter monitor delay gates low/high faults
// - Enhanced mode picks better-integrity input
// - Phase select: 00 short, 10 open, x1 standard
// - Supply mode bit: 1 external amplifier
// - Open low threshold code, resets 111
// - Open high threshold code, resets 111
// - Config B at index 3, resets 07e2
// - Feed-forward disable bit, active low enable
// - Short combine: 0 AND, 1 OR
`ifndef RFD_PARAMS_SVH
`define RFD_PARAMS_SVH

// Register indices; byte address is four times the index
`define RFD_IDX_CFG_A       4'h2
`define RFD_IDX_CFG_B       4'h3
`define RFD_IDX_IRQ_STATUS  4'h4
`define RFD_IDX_IRQ_MASK    4'h5

// Config B fields
`define RFD_B_SHORT_HI      10
`define RFD_B_SHORT_LO      8
`define RFD_B_EXMON_HI      7
`define RFD_B_EXMON_LO      5
`define RFD_B_PHASE_HI      4
`define RFD_B_PHASE_LO      3
`define RFD_B_SUPPLY        2
`define RFD_B_FF_DIS        1
`define RFD_B_COMBINE       0
`define RFD_B_RW_MASK       16'h07ff
`define RFD_B_RESET         16'h07e2

// Config A fields
`define RFD_A_OPEN_LO_HI    5
`define RFD_A_OPEN_LO_LO    3
`define RFD_A_OPEN_HI_HI    2
`define RFD_A_OPEN_HI_LO    0
`define RFD_A_RW_MASK       16'h003f
`define RFD_A_RESET         16'h003f

// Interrupt layout: bit0 short, bit1 exciter low, bit2 exciter high
`define RFD_IRQ_RESET       3'h0

// Timer figures
`define RFD_CLK_MHZ         20
`define RFD_DELAY_BASE_US   35
`define RFD_DELAY_STEP_US   15
`define RFD_BASE_CYC        (`RFD_DELAY_BASE_US * `RFD_CLK_MHZ)
`define RFD_STEP_CYC        (`RFD_DELAY_STEP_US * `RFD_CLK_MHZ)

`endif

/* File: src/rfd_pkg.sv */
/*
 * Types for the resolver fault-detect configuration block.
 * Assumes rfd_params.svh supplies the numeric constants.
 */
package rfd_pkg;
    typedef logic [15:0] rfd_reg_t;
    typedef logic [2:0]  rfd_code_t;
    typedef logic [11:0] rfd_count_t;
    typedef enum logic [1:0] {
        RFD_PH_SHORT,
        RFD_PH_STANDARD,
        RFD_PH_OPEN
    } rfd_phase_mode_t;
endpackage

/* File: src/rfd_top.sv */
/*
 * Fault-detect configuration registers with APB slave, deglitch timers,
 * input selection for phase correction and a masked interrupt.
 * Assumes raw comparator levels arrive asynchronously on pins.
 */
`timescale 1ns/1ps
`include "rfd_params.svh"

module rfd_top
    import rfd_pkg::*;
(
    input  wire logic        pclk,                 // 20 MHz clock
    input  wire logic        presetn,              // Async reset, active low
    input  wire logic        psel,                 // APB select
    input  wire logic        penable,              // APB access phase
    input  wire logic        pwrite,               // APB direction
    input  wire logic [31:0] paddr,                // APB byte address
    input  wire logic [31:0] pwdata,               // APB write data
    output logic      [31:0] prdata,               // APB read data
    output logic             pready,               // APB ready
    output logic             pslverr,              // APB error, unmapped
    input  wire logic        sin_short_raw,        // Sine short comparator
    input  wire logic        cos_short_raw,        // Cosine short comparator
    input  wire logic        exc_low_raw,          // Exciter monitor low
    input  wire logic        exc_high_raw,         // Exciter monitor high
    input  wire logic        sin_integrity_ok,     // Sine integrity good
    input  wire logic        cos_integrity_ok,     // Cosine integrity good
    output logic      [2:0]  open_low_threshold_sel,  // To comparators
    output logic      [2:0]  open_high_threshold_sel, // To comparators
    output logic      [2:0]  short_deglitch_sel,      // Short delay code
    output logic      [2:0]  exciter_monitor_delay_sel, // Monitor code
    output logic             phase_standard,       // Standard auto phase
    output logic             phase_open_thresholds,// Enhanced, open levels
    output logic             phase_use_cos,        // Chosen input is cosine
    output logic             exciter_supply_mode,  // 1: external amplifier
    output logic             feedforward_disable,  // 1: feed-forward off
    output logic             short_combine_select, // 1: OR, 0: AND
    output logic             output_short_fault,   // Deglitched short fault
    output logic             exciter_monitor_low_fault,  // Deglitched
    output logic             exciter_monitor_high_fault, // Deglitched
    output logic             irq                   // Level interrupt
);

    rfd_reg_t        cfg_a;
    rfd_reg_t        cfg_b;
    logic [2:0]      irq_status;
    logic [2:0]      irq_mask;
    logic [5:0]      sync1;
    logic [5:0]      sync2;
    logic [2:0]      cond;
    logic [2:0]      fault;
    logic [2:0]      fault_d;
    rfd_code_t       code [3];
    rfd_count_t      limit [3];
    rfd_count_t      cnt [3];
    rfd_phase_mode_t phase_mode;
    logic [3:0]      idx;
    logic            mapped;
    logic            setup;
    logic            done;
    logic [31:0]     next_rdata;
    logic            wr_cfg_a;
    logic            wr_cfg_b;
    logic            wr_mask;
    logic            rd_status;
    logic            sin_short_s;
    logic            cos_short_s;
    logic            exc_low_s;
    logic            exc_high_s;
    logic            sin_ok_s;
    logic            cos_ok_s;
    logic [2:0]      fault_rise;

    // Bus decode: offsets are word indices, so the low two bits must be zero
    // Anything above the last register index is refused with an error
    assign idx    = paddr[5:2];
    assign mapped = (paddr[31:6] == 26'h0) && (paddr[1:0] == 2'h0) &&
                    (idx == `RFD_IDX_CFG_A || idx == `RFD_IDX_CFG_B ||
                     idx == `RFD_IDX_IRQ_STATUS || idx == `RFD_IDX_IRQ_MASK);
    assign setup  = psel && !penable;
    assign done   = psel && penable && pready;

    // Write and read strobes fire only at the completing access edge
    assign wr_cfg_a  = done && pwrite && mapped && (idx == `RFD_IDX_CFG_A);
    assign wr_cfg_b  = done && pwrite && mapped && (idx == `RFD_IDX_CFG_B);
    assign wr_mask   = done && pwrite && mapped && (idx == `RFD_IDX_IRQ_MASK);
    assign rd_status = done && !pwrite && mapped && (idx == `RFD_IDX_IRQ_STATUS);

    // Registering pready off the setup cycle keeps prdata and pready straight from flip-flops, with no wait state
    // The price is a fixed two-cycle transfer, with no back-pressure
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= setup;
    end

    // Read data and error are captured in the setup cycle
    always_comb
    begin
        next_rdata = 32'h0;
        unique case (idx)
            `RFD_IDX_CFG_A:      next_rdata = {16'h0, cfg_a};
            `RFD_IDX_CFG_B:      next_rdata = {16'h0, cfg_b};
            `RFD_IDX_IRQ_STATUS: next_rdata = {29'h0, irq_status};
            `RFD_IDX_IRQ_MASK:   next_rdata = {29'h0, irq_mask};
            default:             next_rdata = 32'h0;
        endcase
    end

    // Captured once per transfer, so prdata stands until the next setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata  <= (pwrite || !mapped) ? 32'h0 : next_rdata;
            pslverr <= !mapped;
        end
    end

    // Threshold register; only the two open-circuit fields are stored
    // Other bits of this word are reserved and read back as zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cfg_a <= `RFD_A_RESET;
        else if (wr_cfg_a)
            cfg_a <= pwdata[15:0] & `RFD_A_RW_MASK;
    end

    // Config B; upper five bits are never stored so they read as zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cfg_b <= `RFD_B_RESET;
        else if (wr_cfg_b)
            cfg_b <= pwdata[15:0] & `RFD_B_RW_MASK;
    end

    // Interrupt mask
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask <= `RFD_IRQ_RESET;
        else if (wr_mask)
            irq_mask <= pwdata[2:0];
    end

    // Field outputs are register bits, so they come straight from flops
    // Fields take effect on the edge at which the write completes
    assign open_low_threshold_sel    = cfg_a[`RFD_A_OPEN_LO_HI:`RFD_A_OPEN_LO_LO];
    assign open_high_threshold_sel   = cfg_a[`RFD_A_OPEN_HI_HI:`RFD_A_OPEN_HI_LO];
    assign short_deglitch_sel        = cfg_b[`RFD_B_SHORT_HI:`RFD_B_SHORT_LO];
    assign exciter_monitor_delay_sel = cfg_b[`RFD_B_EXMON_HI:`RFD_B_EXMON_LO];
    assign exciter_supply_mode       = cfg_b[`RFD_B_SUPPLY];
    assign feedforward_disable       = cfg_b[`RFD_B_FF_DIS];
    assign short_combine_select      = cfg_b[`RFD_B_COMBINE];

    // Two-stage synchronisers for all asynchronous comparator levels
    // Integrity levels pass the same two stages as the fault levels
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1 <= 6'h0;
            sync2 <= 6'h0;
        end
        else
        begin
            sync1 <= {cos_integrity_ok, sin_integrity_ok, exc_high_raw,
                      exc_low_raw, cos_short_raw, sin_short_raw};
            sync2 <= sync1;
        end
    end

    // Named taps of the second stage; nothing reads the first stage
    assign sin_short_s = sync2[0];
    assign cos_short_s = sync2[1];
    assign exc_low_s   = sync2[2];
    assign exc_high_s  = sync2[3];
    assign sin_ok_s    = sync2[4];
    assign cos_ok_s    = sync2[5];

    // Short condition combines sine and cosine per the combine bit
    assign cond[0] = short_combine_select ? (sin_short_s | cos_short_s)
                                          : (sin_short_s & cos_short_s);
    // Both exciter monitor faults share the one response delay
    assign cond[1] = exc_low_s;
    assign cond[2] = exc_high_s;
    assign code[0] = short_deglitch_sel;
    assign code[1] = exciter_monitor_delay_sel;
    assign code[2] = exciter_monitor_delay_sel;

    // Deglitch timers; a short monitor delay is software's concern
    for (genvar t = 0; t < 3; t++)
    begin : g_timer
        // 35 us plus 15 us per code step, counted in pclk cycles
        // The limit follows the code at once, so a shorter code cuts a count
        assign limit[t] = rfd_count_t'(`RFD_BASE_CYC) +
                          rfd_count_t'(code[t]) * rfd_count_t'(`RFD_STEP_CYC);

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                cnt[t]   <= '0;
                fault[t] <= 1'b0;
            end
            else if (!cond[t])
            begin
                cnt[t]   <= '0;
                fault[t] <= 1'b0;
            end
            else if (cnt[t] >= limit[t] - rfd_count_t'(1))
                fault[t] <= 1'b1;
            else
                cnt[t] <= cnt[t] + rfd_count_t'(1);
        end
    end

    assign output_short_fault         = fault[0];
    assign exciter_monitor_low_fault  = fault[1];
    assign exciter_monitor_high_fault = fault[2];

    // Phase mode decode: low bit set means standard regardless of bit 1
    always_comb
    begin
        if (cfg_b[`RFD_B_PHASE_LO])
            phase_mode = RFD_PH_STANDARD;
        else if (cfg_b[`RFD_B_PHASE_HI])
            phase_mode = RFD_PH_OPEN;
        else
            phase_mode = RFD_PH_SHORT;
    end

    // Decoded mode flags, registered so the outputs come from flip-flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_standard        <= 1'b0;
            phase_open_thresholds <= 1'b0;
        end
        else
        begin
            phase_standard        <= (phase_mode == RFD_PH_STANDARD);
            phase_open_thresholds <= (phase_mode == RFD_PH_OPEN);
        end
    end

    // Input choice: prefer cosine only when it alone has good integrity
    // Standard mode keeps sine; hysteresis-free, so a flickering sine
    // integrity level makes the choice flicker with it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            phase_use_cos <= 1'b0;
        else
            phase_use_cos <= (phase_mode != RFD_PH_STANDARD) &&
                             cos_ok_s && !sin_ok_s;
    end

    // Last fault levels, for rising-edge detection; faults reset to 0 too
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fault_d <= 3'h0;
        else
            fault_d <= fault;
    end

    // A fault sets its status bit once, on its rising edge only
    assign fault_rise = fault & ~fault_d;

    // Sticky status: a read clears only the bits it returned, so an event
    // that lands between the setup and access cycles is kept; set wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_status <= `RFD_IRQ_RESET;
        else if (rd_status)
            irq_status <= (irq_status & ~prdata[2:0]) | fault_rise;
        else
            irq_status <= irq_status | fault_rise;
    end

    // Interrupt level, one cycle behind the masked status
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(irq_status & irq_mask);
    end

endmodule

/* File: verification/rfd_top_props.sv */
/* Checker for rfd_top: APB timing and configuration field outputs.
   Assumes it is bound into rfd_top and sees its ports only. */
`timescale 1ns/1ps
module rfd_top_props
(
    input wire logic        pclk,                       // Clock
    input wire logic        presetn,                    // Reset
    input wire logic        psel,                       // APB
    input wire logic        penable,                    // APB
    input wire logic        pwrite,                     // APB
    input wire logic [31:0] paddr,                      // APB
    input wire logic [31:0] pwdata,                     // APB
    input wire logic [31:0] prdata,                     // APB
    input wire logic        pready,                     // APB
    input wire logic        pslverr,                    // APB
    input wire logic        exc_high_raw,               // Raw level
    input wire logic [2:0]  open_low_threshold_sel,     // Field
    input wire logic [2:0]  open_high_threshold_sel,    // Field
    input wire logic [2:0]  short_deglitch_sel,         // Field
    input wire logic [2:0]  exciter_monitor_delay_sel,  // Field
    input wire logic        phase_standard,             // Decode
    input wire logic        phase_open_thresholds,      // Decode
    input wire logic        exciter_supply_mode,        // Field
    input wire logic        feedforward_disable,        // Field
    input wire logic        short_combine_select,       // Field
    input wire logic        exciter_monitor_high_fault  // Timer
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A completed write; fields must follow it on the next edge
    sequence wr_done(a);
        psel && penable && pready && pwrite && paddr == a;
    endsequence
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready too long");
    ready_next_a: assert property (psel && !penable |=> pready)
        else $error("pready late");
    short_sel_a: assert property (wr_done(32'hc) |=>
        short_deglitch_sel == $past(pwdata[10:8]))
        else $error("short code not loaded");
    exmon_sel_a: assert property (wr_done(32'hc) |=>
        exciter_monitor_delay_sel == $past(pwdata[7:5]))
        else $error("monitor code not loaded");
    low_bits_a: assert property (wr_done(32'hc) |=>
        {exciter_supply_mode, feedforward_disable, short_combine_select}
        == $past(pwdata[2:0])) else $error("low bits not loaded");
    phase_dec_a: assert property (wr_done(32'hc) ##1 1'b1 |=>
        phase_standard == $past(pwdata[3], 2)
        && phase_open_thresholds == ($past(pwdata[4:3], 2) == 2'b10))
        else $error("phase decode");
    thresh_a: assert property (wr_done(32'h8) |=>
        {open_low_threshold_sel, open_high_threshold_sel} == $past(pwdata[5:0]))
        else $error("thresholds not loaded");
    resv_zero_a: assert property (pready && !pwrite && paddr == 32'hc |->
        prdata[31:11] == 0) else $error("reserved bits not zero");
    unmapped_a: assert property (pready && paddr[1:0] != 0 |-> pslverr && prdata == 0)
        else $error("misaligned not refused");
    fault_hold_a: assert property ($rose(exciter_monitor_high_fault) |->
        $past(exc_high_raw, 8) && $past(exc_high_raw, 3))
        else $error("fault without held cause");
endmodule
bind rfd_top rfd_top_props chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .exc_high_raw, .open_low_threshold_sel, .open_high_threshold_sel,
    .short_deglitch_sel, .exciter_monitor_delay_sel, .phase_standard, .phase_open_thresholds,
    .exciter_supply_mode, .feedforward_disable, .short_combine_select, .exciter_monitor_high_fault);

/* File: verification/test_resolver_fault_detect_config.sv */
/* Bench for rfd_top: registers over APB, field decode, fault timers, irq.
   Assumes one 20 MHz clock; the bench drives every port itself. */
`timescale 1ns/1ps
module test_resolver_fault_detect_config;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata, d;
    logic        sin_short_raw = 0, cos_short_raw = 0, exc_low_raw = 0, exc_high_raw = 0;
    logic        sin_integrity_ok = 1, cos_integrity_ok = 1, pready, pslverr, irq, phase_use_cos;
    logic [2:0]  open_low_threshold_sel, open_high_threshold_sel, c, m;
    logic [2:0]  short_deglitch_sel, exciter_monitor_delay_sel;
    logic        phase_standard, phase_open_thresholds, exciter_supply_mode, feedforward_disable;
    logic        short_combine_select, output_short_fault;
    logic        exciter_monitor_low_fault, exciter_monitor_high_fault;
    logic [32:0] exp_q[$];
    int          errors = 0, checks_done = 0, n;
    wire  [2:0]  flt = {exciter_monitor_high_fault, exciter_monitor_low_fault, output_short_fault};
    wire  [10:0] cfg_out = {short_deglitch_sel, exciter_monitor_delay_sel, phase_standard,
        phase_open_thresholds, exciter_supply_mode, feedforward_disable, short_combine_select};

    rfd_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .sin_short_raw, .cos_short_raw, .exc_low_raw, .exc_high_raw, .sin_integrity_ok,
        .cos_integrity_ok, .open_low_threshold_sel, .open_high_threshold_sel, .short_deglitch_sel,
        .exciter_monitor_delay_sel, .phase_standard, .phase_open_thresholds, .phase_use_cos,
        .exciter_supply_mode, .feedforward_disable, .short_combine_select, .output_short_fault,
        .exciter_monitor_low_fault, .exciter_monitor_high_fault, .irq);

    // 50 ns period
    always #25 pclk = ~pclk;

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task close_out;
        $display("Counts: %0d checks, %0d errors", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Hold the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        do
            @(posedge pclk);
        while (!pready);
        psel <= 0;
        penable <= 0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(0, a, 0);
    endtask

    // Cycles until fault w rises; a raw level was raised at the last edge
    task automatic hold_for(input int w, output int cnt);
        cnt = 0;
        do
        begin
            @(posedge pclk);
            cnt++;
        end
        while (!flt[w] && cnt < 4000);
    endtask

    // Read results are compared in order, at the edge that takes them
    always @(posedge pclk)
        if (psel && penable && pready && !pwrite)
            check({pslverr, prdata}, exp_q.pop_front());

    // Watchdog sized well above the longest timer runs
    initial
    begin
        repeat (40000) @(posedge pclk);
        errors++;
        close_out;
    end

    initial
    begin
        void'($urandom(25376));
        repeat (10) @(posedge pclk);
        presetn <= 1;
        check(cfg_out, 16'h07e2);
        check({open_low_threshold_sel, open_high_threshold_sel}, 6'h3f);
        rd(32'h8, 33'h3f);
        rd(32'hc, 33'h7e2);
        rd(32'h14, 33'h0);
        apb(1, 32'h10, 32'h7);
        rd(32'h10, 33'h0);
        apb(1, 32'h20, 32'h1);
        rd(32'h20, {1'b1, 32'h0});
        rd(32'hd, {1'b1, 32'h0});
        // Every code of the short, phase and low Config B fields, random junk in reserved bits
        for (int i = 0; i < 8; i++)
        begin
            c = i[2:0];
            // Monitor delay codes below 010 are never programmed
            m = c | 3'b010;
            d = ($urandom & 32'hffff_f800) | {21'h0, c, m, c[1:0], c};
            apb(1, 32'hc, d);
            repeat (2) @(posedge pclk);
            check(cfg_out, {c, m, c[0], c[1:0] == 2'b10, c});
            check(phase_use_cos, 0);
            rd(32'hc, {1'b0, d & 32'h7ff});
            d = $urandom;
            apb(1, 32'h8, d);
            @(posedge pclk);
            check({open_low_threshold_sel, open_high_threshold_sel}, d[5:0]);
            rd(32'h8, {1'b0, d & 32'h3f});
        end
        sin_integrity_ok <= 0;
        apb(1, 32'hc, 32'he2);
        repeat (5) @(posedge pclk);
        check(phase_use_cos, 1);
        apb(1, 32'h14, 32'h1);
        sin_short_raw <= 1;
        repeat (1000) @(posedge pclk);
        check(flt, 0);
        cos_short_raw <= 1;
        hold_for(0, n);
        check(n >= 701 && n <= 706, 1);
        repeat (3) @(posedge pclk);
        check(irq, 1);
        rd(32'h10, 33'h1);
        repeat (3) @(posedge pclk);
        check(irq, 0);
        sin_short_raw <= 0;
        cos_short_raw <= 0;
        repeat (5) @(posedge pclk);
        check(flt, 0);
        apb(1, 32'hc, 32'he3);
        cos_short_raw <= 1;
        hold_for(0, n);
        check(n >= 701 && n <= 706, 1);
        cos_short_raw <= 0;
        apb(1, 32'h14, 32'h0);
        exc_high_raw <= 1;
        repeat (2000) @(posedge pclk);
        exc_high_raw <= 0;
        repeat (3) @(posedge pclk);
        check(flt, 0);
        exc_high_raw <= 1;
        exc_low_raw <= 1;
        hold_for(2, n);
        check(n >= 2801 && n <= 2806, 1);
        repeat (3) @(posedge pclk);
        check({flt, irq}, 4'b1100);
        rd(32'h10, 33'h7);
        close_out;
    end
endmodule
